// ---- bench/field_valve_model.sv ----
`timescale 1ns/1ps
module field_valve_model
  import aux_pilot_pkg::*;
(
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic contactCmd,
  input wire logic [SAMPLE_W-1:0] sampleCmd,
  input wire logic sendCmd,
  input wire logic countClr,
  // Field pins
  output logic auxContact,
  output logic [SAMPLE_W-1:0] auxSample,
  output logic auxSampleValid,
  input wire logic pilotValve,
  // Valve observation
  output logic [15:0] onCycles
);
  // Switch energized and bus quiet at power-up
  initial
  begin
    auxContact = 1'b1;
    auxSample = 16'h0000;
    auxSampleValid = 1'b0;
    onCycles = 16'h0000;
  end

  // Transmitter strobes one word; between strobes the bus toggles so stale data never looks valid
  always @(posedge clk)
  begin
    auxContact <= contactCmd;
    auxSampleValid <= sendCmd;
    auxSample <= sendCmd ? sampleCmd : ~auxSample;
  end

  // Solenoid counts driven cycles so duty can be measured
  always @(posedge clk)
  begin
    onCycles <= countClr ? 16'h0000 : onCycles + 16'(pilotValve);
  end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import aux_pilot_pkg::*;
;
  localparam int TICK = 8;
  localparam int STEP = 2;
  // Ctrl byte, sample word, expected {lamp, lockout, tripped, range, flame}
  localparam logic [31:0] TBL [10] = '{32'h027FFF00, 32'h0280000C, 32'h0270000C,
    32'h026FFF00, 32'h020BFF1A, 32'h020C0000, 32'h06800001, 32'h067FFF00,
    32'h06010000, 32'h06FFFF01};

  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic auxContact, auxSampleValid, auxFaultLamp, pilotValve, relightRequest, irq;
  logic [SAMPLE_W-1:0] auxSample, sampleCmd;
  logic [3:0] ctrlState;
  logic lockoutRequest, alarmAuxTripped, alarmRangeError, pilotFlameDetected;
  logic contactCmd, sendCmd, countClr;
  logic [15:0] onCycles;
  logic [4:0] flags;
  int mismatches, testsRun, i, s, p;

  assign flags = {auxFaultLamp, lockoutRequest, alarmAuxTripped, alarmRangeError,
    pilotFlameDetected};

  aux_pilot_supervisor #(.TICK_CYCLES(TICK), .PWM_STEP(STEP)) i_aux_pilot_supervisor (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .auxContact(auxContact), .auxSample(auxSample), .auxSampleValid(auxSampleValid),
    .auxFaultLamp(auxFaultLamp), .pilotValve(pilotValve), .ctrlState(ctrlState),
    .relightRequest(relightRequest), .lockoutRequest(lockoutRequest),
    .alarmAuxTripped(alarmAuxTripped), .alarmRangeError(alarmRangeError),
    .pilotFlameDetected(pilotFlameDetected), .irq(irq));

  field_valve_model i_field_valve_model (
    .clk(clk), .contactCmd(contactCmd), .sampleCmd(sampleCmd), .sendCmd(sendCmd),
    .countClr(countClr), .auxContact(auxContact), .auxSample(auxSample),
    .auxSampleValid(auxSampleValid), .pilotValve(pilotValve), .onCycles(onCycles));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; answer taken at the rising edge where pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No local limit: only the watchdog ends a hung wait
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Long enough for the sample to land and a full evaluation tick to pass
  task settle;
    repeat (3 * TICK) @(posedge clk);
    @(negedge clk);
  endtask

  task send(input logic [15:0] v);
    @(posedge clk);
    sampleCmd <= v;
    sendCmd <= 1'b1;
    @(posedge clk);
    sendCmd <= 1'b0;
    settle();
  endtask

  task conclude;
    if (mismatches == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog at 20000 cycles, well beyond the roughly 1300 cycles the run needs
  initial
  begin
    #(20000 * 25);
    mismatches++;
    conclude();
  end

  initial
  begin
    clk = 1'b0;
    mismatches = 0;
    testsRun = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ctrlState = CS_POWER_ON;
    relightRequest = 1'b0;
    contactCmd = 1'b1;
    sampleCmd = 16'h0000;
    sendCmd = 1'b0;
    countClr = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, unmapped access, duty clamp
    rdChk(OFS_CTRL, 32'h0);
    rdChk(OFS_TRIP, 32'h0000FFFF);
    rdChk(OFS_DUTY, 32'h00000064);
    rdChk(OFS_RELIGHT_TO, 32'h0000000A);
    apb(1'b0, 8'h24, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, OFS_DUTY, 32'h7F);
    rdChk(OFS_DUTY, 32'h00000064);
    // Dry contact with temperature mode and zero trip point set: both must be ignored
    send(16'h4000);
    apb(1'b1, OFS_TRIP, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h05);
    settle();
    check(32'(flags), 32'h0);
    @(posedge clk);
    contactCmd <= 1'b0;
    settle();
    check(32'(flags), 32'h0C);
    @(posedge clk);
    contactCmd <= 1'b1;
    settle();
    check(32'(flags), 32'h0);
    // Range error: sticky status, masked then unmasked, cleared by writing one
    send(16'h0BFF);
    check(32'(flags), 32'h1A);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    settle();
    check({31'h0, irq}, 32'h1);
    send(16'h4000);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    check({31'h0, rd[IRQ_RANGE]}, 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h2);
    settle();
    check({31'h0, irq}, 32'h0);
    // Loop high-trip with hysteresis, then temperature flame sensing on the only card
    apb(1'b1, OFS_TRIP, 32'h8000);
    apb(1'b1, OFS_DEADBAND, 32'h1000);
    for (i = 0; i < 10; i++)
    begin
      apb(1'b1, OFS_CTRL, {24'h0, TBL[i][31:24]});
      send(TBL[i][23:8]);
      check(32'(flags), {27'h0, TBL[i][4:0]});
    end
    // Valve by state; policy 3 without main sensing acts as the normal policies
    for (p = 0; p < 4; p++)
    begin
      apb(1'b1, OFS_CTRL, 32'(p) << CTRL_OFF_LSB);
      for (s = 0; s < 11; s++)
      begin
        @(posedge clk);
        ctrlState <= 4'(s);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({31'h0, pilotValve}, 32'(s >= 7));
      end
    end
    // Policy 3 without main sensing in process control: config error and valve demand; with main sensing, valve off in low fire and process
    rdChk(OFS_STATUS, 32'h00000090);
    apb(1'b1, OFS_CTRL, 32'h38);
    for (s = 0; s < 11; s++)
    begin
      @(posedge clk);
      ctrlState <= 4'(s);
      repeat (3) @(posedge clk);
      @(negedge clk);
      check({31'h0, pilotValve}, 32'(s == 7 || s == 8));
    end
    // Relight in low fire, limited by the timeout in ticks
    apb(1'b1, OFS_RELIGHT_TO, 32'h3);
    apb(1'b1, OFS_CTRL, 32'h78);
    @(posedge clk);
    ctrlState <= CS_LOW_FIRE;
    relightRequest <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({31'h0, pilotValve}, 32'h1);
    repeat (6 * TICK) @(posedge clk);
    @(negedge clk);
    check({31'h0, pilotValve}, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    check({31'h0, rd[ST_RELIGHT_EXP]}, 32'h1);
    relightRequest <= 1'b0;
    // Half duty over exactly one period of 100 steps
    apb(1'b1, OFS_DUTY, 32'h32);
    apb(1'b1, OFS_CTRL, 32'h0);
    ctrlState <= CS_PILOT;
    repeat (220) @(posedge clk);
    countClr <= 1'b1;
    @(posedge clk);
    countClr <= 1'b0;
    repeat (100 * STEP) @(posedge clk);
    @(negedge clk);
    check({16'h0, onCycles}, 32'(50 * STEP));
    conclude();
  end
endmodule

// ---- inc/aux_pilot_pkg.sv ----
package aux_pilot_pkg;

  // Bus and data widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned DUTY_W = 7;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIP = 8'h04;
  localparam logic [7:0] OFS_DEADBAND = 8'h08;
  localparam logic [7:0] OFS_DUTY = 8'h0C;
  localparam logic [7:0] OFS_RELIGHT_TO = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_SAMPLE = 8'h20;

  // Control register field positions
  localparam int unsigned CTRL_TYPE_LSB = 0;
  localparam int unsigned CTRL_MODE_BIT = 2;
  localparam int unsigned CTRL_OFF_LSB = 3;
  localparam int unsigned CTRL_MAINFD_BIT = 5;
  localparam int unsigned CTRL_RELIGHT_BIT = 6;
  localparam int unsigned CTRL_W = 7;

  // Status register bit positions
  localparam int unsigned ST_TRIPPED = 0;
  localparam int unsigned ST_RANGE = 1;
  localparam int unsigned ST_FLAME = 2;
  localparam int unsigned ST_LAMP = 3;
  localparam int unsigned ST_VALVE = 4;
  localparam int unsigned ST_LOCKOUT = 5;
  localparam int unsigned ST_RELIGHT_EXP = 6;
  localparam int unsigned ST_CFG_ERR = 7;
  localparam int unsigned STATUS_W = 8;

  // Interrupt bit positions
  localparam int unsigned IRQ_TRIP = 0;
  localparam int unsigned IRQ_RANGE = 1;
  localparam int unsigned IRQ_FLAME = 2;
  localparam int unsigned IRQ_RELIGHT = 3;
  localparam int unsigned IRQ_W = 4;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam logic [SAMPLE_W-1:0] TRIP_RESET = 16'hFFFF;
  localparam logic [SAMPLE_W-1:0] DEADBAND_RESET = 16'h0000;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 7'h64; // 100 percent
  localparam logic [SAMPLE_W-1:0] RELIGHT_TO_RESET = 16'h000A;

  // Out-of-range window defaults for the digitized loop reading
  localparam logic [SAMPLE_W-1:0] RANGE_LO_DEF = 16'h0C00;
  localparam logic [SAMPLE_W-1:0] RANGE_HI_DEF = 16'hF400;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned EVAL_TICK_NS = 1000000;
  localparam int unsigned EVAL_TICK_CYCLES = EVAL_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned PWM_STEP_NS = 1000;
  localparam int unsigned PWM_STEP_CYCLES = PWM_STEP_NS / CLK_PERIOD_NS;

  // Auxiliary input type
  typedef enum logic [1:0] {
    AUX_DISABLED = 2'h0,
    AUX_DRY = 2'h1,
    AUX_LOOP = 2'h2
  } aux_type_e;

  // Auxiliary input mode
  typedef enum logic {
    MODE_HIGH_TRIP = 1'b0,
    MODE_TEMPERATURE_FLAME = 1'b1
  } aux_mode_e;

  // Pilot shutoff policy
  typedef enum logic [1:0] {
    OFF_DISABLED = 2'h0,
    OFF_AT_SETPOINT = 2'h1,
    OFF_FOLLOW_MAIN = 2'h2,
    OFF_AFTER_MAIN_ON = 2'h3
  } pilot_off_e;

  // Controller state as reported by the sequencer
  typedef enum logic [3:0] {
    CS_POWER_ON = 4'h0,
    CS_LOCKOUT = 4'h1,
    CS_ALARM = 4'h2,
    CS_READY = 4'h3,
    CS_WAITING = 4'h4,
    CS_STARTUP = 4'h5,
    CS_PREPURGE = 4'h6,
    CS_IGNITION = 4'h7,
    CS_PILOT = 4'h8,
    CS_LOW_FIRE = 4'h9,
    CS_PROCESS = 4'hA
  } ctrl_state_e;

endpackage

// ---- src/aux_pilot_supervisor.sv ----
// Summary of operation
// - Dry-contact high-trip: closed input harmless, open input locks out, lamp dark.
// - High-trip reading out of range lights lamp and locks out, range error.
// - Trip stays latched until reading drops below trip point minus deadband.
// - Temperature mode: reading at or above trip point means pilot flame present.
// - Dry-contact type works only as high-trip; other aux settings are ignored.
// - Normal policies: valve off before ignition, on in ignition through process.
// - Off-after-main-on: valve off in low fire and process; needs main sensing.
// - Off-after-main-on still re-energizes for relight, bounded by relight timeout.
// - Valve output is PWM with duty setting; 100 percent drives continuously.
`timescale 1ns/1ps
module aux_pilot_supervisor
  import aux_pilot_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = EVAL_TICK_CYCLES,
  parameter logic [SAMPLE_W-1:0] RANGE_LO = RANGE_LO_DEF,
  parameter logic [SAMPLE_W-1:0] RANGE_HI = RANGE_HI_DEF,
  parameter int unsigned PWM_STEP = PWM_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field side
  input wire logic auxContact,
  input wire logic [SAMPLE_W-1:0] auxSample,
  input wire logic auxSampleValid,
  output logic auxFaultLamp,
  output logic pilotValve,
  // Controller state machine side
  input wire logic [3:0] ctrlState,
  input wire logic relightRequest,
  output logic lockoutRequest,
  output logic alarmAuxTripped,
  output logic alarmRangeError,
  output logic pilotFlameDetected,
  // Interrupt
  output logic irq
);

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  typedef struct packed {
    logic contactMeta;
    logic contactSync;
    logic [SAMPLE_W-1:0] sample;
    logic [31:0] tickCnt;
    logic tripLatched;
    logic contactTrip;
    logic rangeError;
    logic flameDetected;
    logic [SAMPLE_W-1:0] relightCnt;
    logic relightExpired;
    logic [CTRL_W-1:0] ctrl;
    logic [SAMPLE_W-1:0] trip;
    logic [SAMPLE_W-1:0] deadband;
    logic [DUTY_W-1:0] duty;
    logic [SAMPLE_W-1:0] relightTimeout;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
  } sup_s;

  sup_s state;
  sup_s next_state;

  // Decoded configuration
  aux_type_e auxType;
  aux_mode_e auxMode;
  pilot_off_e offMode;
  logic mainFlameEn;
  logic relightEn;
  logic isDry;
  logic isLoopTrip;
  logic isLoopFlame;
  logic tick;
  logic inRange;
  logic [SAMPLE_W-1:0] clearLevel;
  logic firingState;
  logic mainState;
  logic offAfterMain;
  logic relightOn;
  logic valveDemand;
  logic cfgError;
  logic auxTripped;
  logic setupPhase;
  logic writeAccess;
  logic addrHit;
  logic [IRQ_W-1:0] irqEvent;
  logic [STATUS_W-1:0] statusWord;

  assign auxType = aux_type_e'(state.ctrl[CTRL_TYPE_LSB +: 2]);
  assign auxMode = aux_mode_e'(state.ctrl[CTRL_MODE_BIT]);
  assign offMode = pilot_off_e'(state.ctrl[CTRL_OFF_LSB +: 2]);
  assign mainFlameEn = state.ctrl[CTRL_MAINFD_BIT];
  assign relightEn = state.ctrl[CTRL_RELIGHT_BIT];

  // Dry contact overrides the mode bit, so trip point and deadband go unused
  assign isDry = (auxType == AUX_DRY);
  assign isLoopTrip = (auxType == AUX_LOOP) && (auxMode == MODE_HIGH_TRIP);
  assign isLoopFlame = (auxType == AUX_LOOP) && (auxMode == MODE_TEMPERATURE_FLAME);
  assign tick = (state.tickCnt == TICK_LAST);
  assign inRange = (state.sample >= RANGE_LO) && (state.sample <= RANGE_HI);
  // Saturate so a deadband wider than the trip point cannot wrap around
  assign clearLevel = (state.deadband > state.trip) ? '0 : state.trip - state.deadband;

  // Valve gating by controller state and shutoff policy
  assign firingState = (ctrlState == CS_IGNITION) || (ctrlState == CS_PILOT)
    || (ctrlState == CS_LOW_FIRE) || (ctrlState == CS_PROCESS);
  assign mainState = (ctrlState == CS_LOW_FIRE) || (ctrlState == CS_PROCESS);
  // Without main sensing the pilot is the only proof of flame, so it stays lit
  assign offAfterMain = (offMode == OFF_AFTER_MAIN_ON) && mainFlameEn;
  assign cfgError = (offMode == OFF_AFTER_MAIN_ON) && !mainFlameEn;
  assign relightOn = relightEn && relightRequest && !state.relightExpired;
  assign valveDemand = firingState && !(offAfterMain && mainState && !relightOn);

  // Trip and lockout outputs
  assign auxTripped = state.contactTrip || state.tripLatched;

  always_comb
  begin
    statusWord = '0;
    statusWord[ST_TRIPPED] = auxTripped;
    statusWord[ST_RANGE] = state.rangeError;
    statusWord[ST_FLAME] = state.flameDetected;
    statusWord[ST_LAMP] = state.rangeError;
    statusWord[ST_VALVE] = valveDemand;
    statusWord[ST_LOCKOUT] = auxTripped || state.rangeError;
    statusWord[ST_RELIGHT_EXP] = state.relightExpired;
    statusWord[ST_CFG_ERR] = cfgError;
  end

  // APB decode; zero wait states, read data captured in the setup cycle
  assign setupPhase = psel && !penable;
  assign writeAccess = psel && penable && pwrite;
  assign addrHit = (paddr[1:0] == 2'h0) && (paddr <= OFS_SAMPLE);

  // Evaluation, hysteresis and register file
  always_comb
  begin
    next_state = state;
    next_state.contactMeta = auxContact;
    next_state.contactSync = state.contactMeta;
    if (auxSampleValid)
      next_state.sample = auxSample;
    next_state.tickCnt = tick ? '0 : state.tickCnt + 32'h1;
    // Contact follows the pin; an open loop reads as de-energized
    next_state.contactTrip = isDry && !state.contactSync;
    if (tick)
    begin
      next_state.rangeError = (isDry || isLoopTrip) && !inRange;
      if (!isLoopTrip)
        next_state.tripLatched = 1'b0;
      else if (state.sample >= state.trip)
        next_state.tripLatched = 1'b1;
      else if (state.sample < clearLevel)
        next_state.tripLatched = 1'b0;
      next_state.flameDetected = isLoopFlame && (state.sample >= state.trip);
    end
    else if (!(isDry || isLoopTrip))
    begin
      next_state.rangeError = 1'b0;
    end
    if (!isLoopFlame)
      next_state.flameDetected = 1'b0;
    // Relight window counts ticks while relight re-energizes the pilot after main on
    if (!(relightRequest && offAfterMain && mainState && relightEn))
    begin
      next_state.relightCnt = '0;
      next_state.relightExpired = 1'b0;
    end
    else if (tick && !state.relightExpired)
    begin
      next_state.relightCnt = state.relightCnt + 16'h0001;
      if (state.relightCnt + 16'h0001 >= state.relightTimeout)
        next_state.relightExpired = 1'b1;
    end
    // Bus access
    if (setupPhase)
    begin
      next_state.pslverr = !addrHit;
      next_state.prdata = '0;
      unique case (paddr)
        OFS_CTRL: next_state.prdata[CTRL_W-1:0] = state.ctrl;
        OFS_TRIP: next_state.prdata[SAMPLE_W-1:0] = state.trip;
        OFS_DEADBAND: next_state.prdata[SAMPLE_W-1:0] = state.deadband;
        OFS_DUTY: next_state.prdata[DUTY_W-1:0] = state.duty;
        OFS_RELIGHT_TO: next_state.prdata[SAMPLE_W-1:0] = state.relightTimeout;
        OFS_STATUS: next_state.prdata[STATUS_W-1:0] = statusWord;
        OFS_IRQ_STAT: next_state.prdata[IRQ_W-1:0] = state.irqStat;
        OFS_IRQ_MASK: next_state.prdata[IRQ_W-1:0] = state.irqMask;
        OFS_SAMPLE: next_state.prdata[SAMPLE_W-1:0] = state.sample;
        default: next_state.prdata = '0;
      endcase
    end
    if (writeAccess)
    begin
      unique case (paddr)
        OFS_CTRL: next_state.ctrl = pwdata[CTRL_W-1:0];
        OFS_TRIP: next_state.trip = pwdata[SAMPLE_W-1:0];
        OFS_DEADBAND: next_state.deadband = pwdata[SAMPLE_W-1:0];
        OFS_DUTY: next_state.duty = (pwdata[DUTY_W-1:0] > DUTY_FULL) ? DUTY_FULL
          : pwdata[DUTY_W-1:0];
        OFS_RELIGHT_TO: next_state.relightTimeout = pwdata[SAMPLE_W-1:0];
        OFS_IRQ_STAT: next_state.irqStat = state.irqStat & ~pwdata[IRQ_W-1:0];
        OFS_IRQ_MASK: next_state.irqMask = pwdata[IRQ_W-1:0];
        default: next_state.irqMask = state.irqMask;
      endcase
    end
    // Events are edges of the next state, kept here so no path loops back out of this process
    irqEvent[IRQ_TRIP] = !auxTripped && (next_state.contactTrip || next_state.tripLatched);
    irqEvent[IRQ_RANGE] = !state.rangeError && next_state.rangeError;
    irqEvent[IRQ_FLAME] = state.flameDetected != next_state.flameDetected;
    irqEvent[IRQ_RELIGHT] = !state.relightExpired && next_state.relightExpired;
    // New events win over a clear in the same cycle
    next_state.irqStat = next_state.irqStat | irqEvent;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state <= '0;
      state.contactMeta <= 1'b1;
      state.contactSync <= 1'b1;
      state.ctrl <= CTRL_RESET;
      state.trip <= TRIP_RESET;
      state.deadband <= DEADBAND_RESET;
      state.duty <= DUTY_FULL;
      state.relightTimeout <= RELIGHT_TO_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  pilot_pwm #(
    .STEP_CYCLES(PWM_STEP)
  ) valvePwm (
    .clk(clk),
    .rst_b(rst_b),
    .enable(valveDemand),
    .duty(state.duty),
    .drive(pilotValve)
  );

  // Outputs
  assign prdata = state.prdata;
  assign pready = 1'b1;
  assign pslverr = state.pslverr && psel && penable;
  assign auxFaultLamp = state.rangeError;
  assign alarmAuxTripped = auxTripped;
  assign alarmRangeError = state.rangeError;
  assign lockoutRequest = auxTripped || state.rangeError;
  assign pilotFlameDetected = state.flameDetected;
  assign irq = |(state.irqStat & state.irqMask);

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_DRY_OPEN_LOCKS: assert property (
    isDry && !state.contactSync ##1 isDry |-> lockoutRequest && alarmAuxTripped)
    else $error("open dry contact did not lock out");
  AST_RANGE_LAMP: assert property (
    tick && (isDry || isLoopTrip) && !inRange |=> auxFaultLamp && lockoutRequest)
    else $error("out of range without lamp and lockout");
  AST_LOOP_TRIP: assert property (
    tick && isLoopTrip && state.sample >= state.trip |=> alarmAuxTripped)
    else $error("reading at trip point did not trip");
  AST_HYSTERESIS_HOLD: assert property (
    state.tripLatched && isLoopTrip && state.sample >= clearLevel |=> state.tripLatched)
    else $error("trip cleared inside deadband");
  AST_FLAME_SENSE: assert property (
    tick && isLoopFlame |=> pilotFlameDetected == ($past(state.sample) >= $past(state.trip))
      && !auxFaultLamp)
    else $error("flame status does not follow trip point");
  AST_DRY_IGNORES: assert property (
    isDry && tick |=> !state.tripLatched && !pilotFlameDetected)
    else $error("dry contact used loop settings");
  AST_VALVE_OFF_EARLY: assert property (
    !firingState [*3] |-> !pilotValve)
    else $error("valve energized before ignition");
  AST_OFF_AFTER_MAIN: assert property (
    offAfterMain && mainState && !relightRequest [*3] |-> !pilotValve)
    else $error("valve on after main under off policy");
  AST_RELIGHT_BOUND: assert property (
    state.relightExpired |-> state.relightCnt >= state.relightTimeout || !relightEn)
    else $error("relight window ended early");
  AST_FULL_DUTY: assert property (
    valveDemand && state.duty == DUTY_FULL ##1 valveDemand && state.duty == DUTY_FULL
      |=> pilotValve)
    else $error("full duty not continuous");
  AST_TICK_PERIOD: assert property (
    tick |=> !tick && state.tickCnt == 32'h0)
    else $error("evaluation tick cadence wrong");

endmodule

// ---- src/pilot_pwm.sv ----
`timescale 1ns/1ps
module pilot_pwm
  import aux_pilot_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = PWM_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Demand and duty
  input wire logic enable,
  input wire logic [DUTY_W-1:0] duty,
  // Valve drive
  output logic drive
);

  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);
  localparam logic [DUTY_W-1:0] PHASE_LAST = DUTY_FULL - 7'h01;

  typedef struct packed {
    logic [15:0] stepCnt;
    logic [DUTY_W-1:0] phase;
    logic drive;
  } pwm_s;

  pwm_s state;
  pwm_s next_state;

  // Phase advances one step per prescaled tick; full duty never drops
  always_comb
  begin
    next_state = state;
    if (state.stepCnt == STEP_LAST)
    begin
      next_state.stepCnt = 16'h0000;
      next_state.phase = (state.phase == PHASE_LAST) ? 7'h00 : state.phase + 7'h01;
    end
    else
    begin
      next_state.stepCnt = state.stepCnt + 16'h0001;
    end
    next_state.drive = enable && (duty >= DUTY_FULL || state.phase < duty);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state <= '0;
    else
      state <= next_state;
  end

  assign drive = state.drive;

endmodule
